//--- rtl/scec_ctrl.sv
// conditional execution gating and interlock for a two-lane core
// Functional notes
// [RL1] y-lane explicit store written only when y lane condition true.
// [RL2] paired x-lane word goes to index plus n only if x true.
// [RL3] n is 1 in normal word space, 2 in short word space.
// [RL4] software keeps index even for y-explicit SIMD store.
// [RL5] address generator load suppressed when both lane conditions false.
// [RL6] address generator load done when either lane condition true.
// [RL7] software avoids conditional pair-to-single moves in peripheral space.
// [RL8] SIMD branches and loops taken only when both lanes true.
// [RL9] computes are no-ops in lanes where the condition is false.
// [RL10] direct conditional branch accepted only in type 8.
// [RL11] indirect conditional branch accepted in types 9, 10, 11.
// [RL12] single-lane: IF when true, ELSE compute only when false.
// [RL13] SIMD: IF needs both lanes; ELSE per lane on own false.
// [RL14] short word space decodes type 10 as plain compute.
// [RL15] pipeline fully interlocked, stalls inserted by hardware.
// [RL16] stall on same-cycle resource conflict between stages.
// [RL17] stall reader of register or flag still being updated.
// [RL18] post-modify on either lane true; data per own lane.
// [RL19] each lane evaluates condition from its own status flags.
`timescale 1ns/1ps
module scec_ctrl
    import scec_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        simd_mode,
    input  wire logic        short_word_space,
    input  wire scec_flags_t x_lane_flags,
    input  wire scec_flags_t y_lane_flags,
    input  wire scec_instr_t instr,
    input  wire logic        exec_mem_busy,
    output scec_store_t      store_q,
    output scec_exec_t       exec_q,
    output logic             type10_compute_q,
    output logic             illegal_q,
    output logic             stall_q
);

    logic x_cond;
    logic y_cond;

    scec_cond_eval u_x_eval (
        .cond   (instr.cond),
        .flags  (x_lane_flags),
        .result (x_cond)
    );

    scec_cond_eval u_y_eval (
        .cond   (instr.cond),
        .flags  (y_lane_flags),
        .result (y_cond)
    );

    // in single-lane mode the y lane is idle
    logic y_eff;
    assign y_eff = simd_mode & y_cond;

    function automatic logic is_indirect(input logic [3:0] t);
        is_indirect = (t >= TYPE_IND_LO) && (t <= TYPE_IND_HI);
    endfunction

    // pending writers in flight, for interlock
    logic [REG_W-1:0] pend_reg_q,   pend_reg_d;
    logic             pend_reg_v_q, pend_reg_v_d;
    logic             pend_flag_q,  pend_flag_d;
    logic [1:0]       ag_cnt_q,     ag_cnt_d;

    logic             stall;
    logic             issue;

    // [RL15] hazard detection
    always_comb begin
        stall = 1'b0;
        // [RL16] resource conflict
        if (instr.valid && instr.mem_use && exec_mem_busy) begin
            stall = 1'b1;
        end
        // [RL17] register or flag still updating
        if (instr.valid && pend_reg_v_q && instr.rd_reg == pend_reg_q) begin
            stall = 1'b1;
        end
        if (instr.valid && instr.rd_flags && pend_flag_q) begin
            stall = 1'b1;
        end
        if (instr.valid && instr.mem_use && ag_cnt_q != 2'h0) begin
            stall = 1'b1;
        end
    end

    assign issue = instr.valid && !stall;

    always_comb begin
        pend_reg_v_d = 1'b0;
        pend_reg_d   = pend_reg_q;
        pend_flag_d  = 1'b0;
        ag_cnt_d     = (ag_cnt_q != 2'h0) ? ag_cnt_q - 2'h1 : 2'h0;
        if (issue) begin
            pend_reg_v_d = instr.wr_reg_en;
            pend_reg_d   = instr.wr_reg;
            pend_flag_d  = instr.wr_flags;
            if (instr.op == SCEC_OP_LOAD_AG) begin
                ag_cnt_d = STALL_ADDR_GEN;
            end
        end
    end

    // decode and gating
    scec_store_t st_d;
    scec_exec_t  ex_d;
    logic        t10_d;
    logic        ill_d;
    logic        any_true;
    logic        both_true;
    logic [ADDR_W-1:0] n_off;

    always_comb begin
        st_d      = '0;
        ex_d      = '0;
        t10_d     = 1'b0;
        ill_d     = 1'b0;
        any_true  = x_cond | y_eff;
        // [RL8] branch needs both lanes in SIMD
        both_true = simd_mode ? (x_cond & y_cond) : x_cond;
        // [RL3] implicit lane offset
        n_off     = short_word_space ? OFFS_SHORT : OFFS_NORMAL;
        if (issue) begin
            case (instr.op)
                SCEC_OP_STORE: begin
                    if (instr.src_y && simd_mode) begin
                        // [RL1] y explicit at index
                        st_d.y_en   = y_cond;
                        st_d.y_addr = instr.index;
                        // [RL2] x paired at index plus n
                        st_d.x_en   = x_cond;
                        st_d.x_addr = instr.index + n_off;
                    end else begin
                        st_d.x_en   = x_cond;
                        st_d.x_addr = instr.index;
                        st_d.y_en   = y_eff;
                        st_d.y_addr = instr.index + n_off;
                    end
                    // [RL18] post-modify on either lane
                    ex_d.post_mod = any_true;
                end
                SCEC_OP_LOAD_AG: begin
                    // [RL5] [RL6] either lane true writes
                    ex_d.ag_write = any_true;
                    ex_d.post_mod = any_true;
                end
                SCEC_OP_BRANCH: begin
                    if (short_word_space && instr.itype == TYPE_ELSE_MEM) begin
                        // [RL14] plain compute in short word space
                        t10_d     = 1'b1;
                        ex_d.x_if = 1'b1;
                        ex_d.y_if = simd_mode;
                    end else if (instr.itype == TYPE_DIRECT
                                 && !instr.has_else) begin
                        // [RL10] direct form
                        ex_d.branch_take = both_true;
                        // [RL9] compute per lane
                        ex_d.x_if = x_cond;
                        ex_d.y_if = y_eff;
                    end else if (is_indirect(instr.itype)) begin
                        // [RL11] indirect forms
                        // [RL12] [RL13] if needs all, else per lane
                        ex_d.branch_take = both_true;
                        ex_d.x_if = x_cond;
                        ex_d.y_if = y_eff;
                        if (instr.has_else) begin
                            ex_d.x_else = !x_cond;
                            ex_d.y_else = simd_mode & !y_cond;
                        end
                    end else begin
                        ill_d = 1'b1;
                    end
                end
                default: begin
                    ex_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            store_q          <= '0;
            exec_q           <= '0;
            type10_compute_q <= 1'b0;
            illegal_q        <= 1'b0;
            stall_q          <= 1'b0;
            pend_reg_q       <= '0;
            pend_reg_v_q     <= 1'b0;
            pend_flag_q      <= 1'b0;
            ag_cnt_q         <= 2'h0;
        end else begin
            store_q          <= st_d;
            exec_q           <= ex_d;
            type10_compute_q <= t10_d;
            illegal_q        <= ill_d;
            stall_q          <= stall;
            pend_reg_q       <= pend_reg_d;
            pend_reg_v_q     <= pend_reg_v_d;
            pend_flag_q      <= pend_flag_d;
            ag_cnt_q         <= ag_cnt_d;
        end
    end

    // assertions
    sequence s_simd_branch;
        issue && simd_mode && instr.op == SCEC_OP_BRANCH
            && !(short_word_space && instr.itype == TYPE_ELSE_MEM);
    endsequence

    property p_y_store;
        @(posedge clock) disable iff (!reset_n)
        issue && simd_mode && instr.op == SCEC_OP_STORE && instr.src_y
            |=> store_q.y_en == $past(y_cond)
                && store_q.y_addr == $past(instr.index);
    endproperty
    a_y_store: assert property (p_y_store) // [RL1]
        else $error("y explicit store gating wrong");

    property p_x_paired;
        @(posedge clock) disable iff (!reset_n)
        issue && simd_mode && instr.op == SCEC_OP_STORE && instr.src_y
            |=> store_q.x_en == $past(x_cond);
    endproperty
    a_x_paired: assert property (p_x_paired) // [RL2]
        else $error("x paired store gating wrong");

    property p_offset;
        @(posedge clock) disable iff (!reset_n)
        issue && simd_mode && instr.op == SCEC_OP_STORE && instr.src_y
            |=> store_q.x_addr - store_q.y_addr
                == ($past(short_word_space) ? OFFS_SHORT : OFFS_NORMAL);
    endproperty
    a_offset: assert property (p_offset) // [RL3]
        else $error("implicit offset wrong");

    property p_ag_none;
        @(posedge clock) disable iff (!reset_n)
        issue && instr.op == SCEC_OP_LOAD_AG && !x_cond && !y_eff
            |=> !exec_q.ag_write;
    endproperty
    a_ag_none: assert property (p_ag_none) // [RL5]
        else $error("address generator write not suppressed");

    property p_ag_any;
        @(posedge clock) disable iff (!reset_n)
        issue && instr.op == SCEC_OP_LOAD_AG && (x_cond || y_eff)
            |=> exec_q.ag_write && exec_q.post_mod;
    endproperty
    a_ag_any: assert property (p_ag_any) // [RL6]
        else $error("address generator write missed");

    property p_branch_and;
        @(posedge clock) disable iff (!reset_n)
        s_simd_branch |=> exec_q.branch_take == $past(x_cond && y_cond)
            || illegal_q;
    endproperty
    a_branch_and: assert property (p_branch_and) // [RL8]
        else $error("SIMD branch not ANDed");

    property p_else_lane;
        @(posedge clock) disable iff (!reset_n)
        s_simd_branch ##0 instr.has_else && is_indirect(instr.itype)
            |=> exec_q.y_else == $past(!y_cond)
                && exec_q.x_else == $past(!x_cond);
    endproperty
    a_else_lane: assert property (p_else_lane) // [RL13]
        else $error("else lane enable wrong");

    property p_flag_stall;
        @(posedge clock) disable iff (!reset_n)
        pend_flag_q && instr.valid && instr.rd_flags
            |=> stall_q && exec_q == '0 && store_q == '0;
    endproperty
    a_flag_stall: assert property (p_flag_stall) // [RL17]
        else $error("flag hazard not stalled");

    property p_ag_stall;
        @(posedge clock) disable iff (!reset_n)
        issue && instr.op == SCEC_OP_LOAD_AG
            |=> (instr.valid && instr.mem_use) |-> stall;
    endproperty
    a_ag_stall: assert property (p_ag_stall) // [RL17]
        else $error("address generator reload not stalled");

    property p_mem_conflict;
        @(posedge clock) disable iff (!reset_n)
        instr.valid && instr.mem_use && exec_mem_busy
            |=> stall_q && store_q == '0;
    endproperty
    a_mem_conflict: assert property (p_mem_conflict) // [RL16]
        else $error("memory conflict not stalled");

    property p_single_lane;
        @(posedge clock) disable iff (!reset_n)
        issue && !simd_mode
            |=> !store_q.y_en && !exec_q.y_if && !exec_q.y_else;
    endproperty
    a_single_lane: assert property (p_single_lane) // [RL12]
        else $error("y lane active in single lane mode");

endmodule

//--- inc/scec_pkg.sv
// package: shared types and constants for conditional execution control
package scec_pkg;

    localparam int ADDR_W = 32;
    localparam int REG_W  = 5;

    // implicit lane address offsets
    localparam logic [ADDR_W-1:0] OFFS_NORMAL = 32'h0000_0001;
    localparam logic [ADDR_W-1:0] OFFS_SHORT  = 32'h0000_0002;

    // instruction types that carry conditional branch forms
    localparam logic [3:0] TYPE_DIRECT = 4'h8;
    localparam logic [3:0] TYPE_IND_LO = 4'h9;
    localparam logic [3:0] TYPE_IND_HI = 4'hB;
    localparam logic [3:0] TYPE_ELSE_MEM = 4'hA;

    // hazard stall length for address generator reloads
    localparam logic [1:0] STALL_ADDR_GEN = 2'h2;

    typedef enum logic [1:0] {
        SCEC_OP_NONE,
        SCEC_OP_STORE,
        SCEC_OP_LOAD_AG,
        SCEC_OP_BRANCH
    } scec_op_t;

    // per-lane arithmetic status flags
    typedef struct packed {
        logic zero;
        logic neg;
    } scec_flags_t;

    // decoded instruction in the decode stage
    typedef struct packed {
        logic            valid;
        scec_op_t        op;
        logic [3:0]      itype;
        logic [3:0]      cond;
        logic            has_else;
        logic            src_y;
        logic [ADDR_W-1:0] index;
        logic [REG_W-1:0] rd_reg;
        logic            rd_flags;
        logic [REG_W-1:0] wr_reg;
        logic            wr_reg_en;
        logic            wr_flags;
        logic            ag_write;
        logic            mem_use;
    } scec_instr_t;

    // memory store requests for both lanes
    typedef struct packed {
        logic            x_en;
        logic [ADDR_W-1:0] x_addr;
        logic            y_en;
        logic [ADDR_W-1:0] y_addr;
    } scec_store_t;

    // per-lane execute enables
    typedef struct packed {
        logic branch_take;
        logic x_if;
        logic y_if;
        logic x_else;
        logic y_else;
        logic ag_write;
        logic post_mod;
    } scec_exec_t;

    localparam logic [3:0] COND_EQ = 4'h0;
    localparam logic [3:0] COND_NE = 4'h1;
    localparam logic [3:0] COND_LT = 4'h2;
    localparam logic [3:0] COND_GE = 4'h3;
    localparam logic [3:0] COND_TRUE = 4'hF;

endpackage

//--- rtl/scec_cond_eval.sv
// one lane's condition evaluator
`timescale 1ns/1ps
module scec_cond_eval
    import scec_pkg::*;
(
    input  wire logic [3:0]  cond,
    input  wire scec_flags_t flags,
    output logic             result
);

    // [RL19] own lane flags
    always_comb begin
        case (cond)
            COND_EQ:   result = flags.zero;
            COND_NE:   result = !flags.zero;
            COND_LT:   result = flags.neg;
            COND_GE:   result = !flags.neg;
            COND_TRUE: result = 1'b1;
            default:   result = 1'b0;
        endcase
    end

endmodule

//--- test/scec_tb.sv
// self-checking testbench for conditional execution control
`timescale 1ns/1ps
module testbench
    import scec_pkg::*;
;
    localparam logic [ADDR_W-1:0] IDX = 32'h0000_0100;

    logic        clock;
    logic        reset_n;
    logic        simd_mode;
    logic        short_word_space;
    logic        exec_mem_busy;
    scec_flags_t x_lane_flags;
    scec_flags_t y_lane_flags;
    scec_instr_t instr;
    scec_store_t store_q;
    scec_exec_t  exec_q;
    logic        type10_compute_q;
    logic        illegal_q;
    logic        stall_q;
    int          mismatches;
    int          check_count;
    int          cycles;

    scec_ctrl i_dut (
        .clock            (clock),
        .reset_n          (reset_n),
        .simd_mode        (simd_mode),
        .short_word_space (short_word_space),
        .x_lane_flags     (x_lane_flags),
        .y_lane_flags     (y_lane_flags),
        .instr            (instr),
        .exec_mem_busy    (exec_mem_busy),
        .store_q          (store_q),
        .exec_q           (exec_q),
        .type10_compute_q (type10_compute_q),
        .illegal_q        (illegal_q),
        .stall_q          (stall_q)
    );

    initial clock = 1'b0;
    always #10 clock = ~clock;

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_addr(input logic [ADDR_W-1:0] got,
                              input logic [ADDR_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic scec_instr_t mk(input scec_op_t op, input logic [3:0] t,
        input logic [3:0] c, input logic e, input logic sy, input logic mu);
        scec_instr_t i;
        i = '0;
        i.valid = 1'b1;
        i.op = op;
        i.itype = t;
        i.cond = c;
        i.has_else = e;
        i.src_y = sy;
        i.mem_use = mu;
        i.index = IDX;
        return i;
    endfunction

    task automatic lanes(input logic s, input scec_flags_t x,
                         input scec_flags_t y);
        simd_mode = s;
        x_lane_flags = x;
        y_lane_flags = y;
    endtask

    // present, sample the registered answer; held until replaced
    task automatic issue(input scec_instr_t i);
        instr = i;
        @(posedge clock);
        #1;
    endtask

    task automatic t_store();
        logic [ADDR_W-1:0] n;
        for (int k = 0; k < 16; k++) begin
            lanes(1'b1, {k[0], 1'b0}, {k[1], 1'b0});
            short_word_space = k[2];
            n = k[2] ? OFFS_SHORT : OFFS_NORMAL;
            issue(mk(SCEC_OP_STORE, 4'h0, COND_EQ, 1'b0, k[3], 1'b0));
            check_flag(store_q.x_en, k[0]);
            check_flag(store_q.y_en, k[1]);
            check_flag(exec_q.post_mod, k[0] | k[1]);
            if (k[0]) begin
                check_addr(store_q.x_addr, k[3] ? IDX + n : IDX);
            end
            if (k[1]) begin
                check_addr(store_q.y_addr, k[3] ? IDX : IDX + n);
            end
        end
        short_word_space = 1'b0;
        lanes(1'b0, 2'h2, 2'h2);
        issue(mk(SCEC_OP_STORE, 4'h0, COND_EQ, 1'b0, 1'b0, 1'b0));
        check_flag(store_q.x_en, 1'b1);
        check_flag(store_q.y_en, 1'b0);
    endtask

    task automatic t_load();
        for (int k = 0; k < 4; k++) begin
            lanes(1'b1, {k[0], 1'b0}, {k[1], 1'b0});
            issue(mk(SCEC_OP_LOAD_AG, 4'h0, COND_EQ, 1'b0, 1'b0, 1'b0));
            check_flag(exec_q.ag_write, k[0] | k[1]);
            check_flag(exec_q.post_mod, k[0] | k[1]);
        end
    endtask

    task automatic t_branch();
        logic [3:0] t;
        logic       e;
        for (int k = 0; k < 16; k++) begin
            t = TYPE_DIRECT + 4'(k[3:2]);
            e = (t != TYPE_DIRECT);
            lanes(1'b1, {k[0], 1'b0}, {k[1], 1'b0});
            issue(mk(SCEC_OP_BRANCH, t, COND_EQ, e, 1'b0, 1'b0));
            check_flag(exec_q.branch_take, k[0] & k[1]);
            check_flag(exec_q.x_if, k[0]);
            check_flag(exec_q.y_if, k[1]);
            check_flag(exec_q.x_else, e & !k[0]);
            check_flag(exec_q.y_else, e & !k[1]);
            check_flag(illegal_q, 1'b0);
        end
        for (int k = 0; k < 2; k++) begin
            lanes(1'b0, {k[0], 1'b0}, 2'h2);
            issue(mk(SCEC_OP_BRANCH, TYPE_IND_LO, COND_EQ, 1'b1, 1'b0, 1'b0));
            check_flag(exec_q.branch_take, k[0]);
            check_flag(exec_q.x_if, k[0]);
            check_flag(exec_q.x_else, !k[0]);
            check_flag(exec_q.y_else, 1'b0);
        end
    endtask

    task automatic t_codes();
        logic [3:0] c [5] = '{COND_NE, COND_NE, COND_LT, COND_GE, COND_TRUE};
        logic [1:0] f [5] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h0};
        logic       x [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 5; k++) begin
            lanes(1'b0, f[k], 2'h0);
            issue(mk(SCEC_OP_BRANCH, TYPE_IND_HI, c[k], 1'b0, 1'b0, 1'b0));
            check_flag(exec_q.branch_take, x[k]);
        end
    endtask

    task automatic t_illegal();
        lanes(1'b1, 2'h2, 2'h2);
        issue(mk(SCEC_OP_BRANCH, TYPE_DIRECT, COND_EQ, 1'b1, 1'b0, 1'b0));
        check_flag(illegal_q, 1'b1);
        issue(mk(SCEC_OP_BRANCH, 4'h5, COND_EQ, 1'b0, 1'b0, 1'b0));
        check_flag(illegal_q, 1'b1);
        short_word_space = 1'b1;
        issue(mk(SCEC_OP_BRANCH, TYPE_ELSE_MEM, COND_EQ, 1'b1, 1'b0, 1'b0));
        check_flag(type10_compute_q, 1'b1);
        check_flag(exec_q.branch_take, 1'b0);
        short_word_space = 1'b0;
    endtask

    task automatic t_stall();
        scec_instr_t i;
        int          n;
        lanes(1'b1, 2'h2, 2'h2);
        exec_mem_busy = 1'b1;
        instr = mk(SCEC_OP_STORE, 4'h0, COND_EQ, 1'b0, 1'b0, 1'b1);
        @(posedge clock);
        #1;
        exec_mem_busy = 1'b0;
        check_flag(store_q.x_en, 1'b0);
        check_flag(stall_q, 1'b1);
        @(posedge clock);
        #1;
        instr = mk(SCEC_OP_LOAD_AG, 4'h0, COND_EQ, 1'b0, 1'b0, 1'b0);
        check_flag(store_q.x_en, 1'b1);
        @(posedge clock);
        #1;
        instr = mk(SCEC_OP_STORE, 4'h0, COND_EQ, 1'b0, 1'b0, 1'b1);
        n = 0;
        while (store_q.x_en !== 1'b1 && n < 10) begin
            @(posedge clock);
            #1;
            n++;
        end
        // two stall cycles, then the registered answer
        check_addr(32'(n), 32'(STALL_ADDR_GEN) + 32'h1);
        // flag writer, then its reader back to back
        i = mk(SCEC_OP_BRANCH, TYPE_IND_LO, COND_EQ, 1'b0, 1'b0, 1'b0);
        i.wr_flags = 1'b1;
        instr = i;
        @(posedge clock);
        #1;
        i.wr_flags = 1'b0;
        i.rd_flags = 1'b1;
        instr = i;
        check_flag(exec_q.branch_take, 1'b1);
        @(posedge clock);
        #1;
        check_flag(stall_q, 1'b1);
        check_flag(exec_q.branch_take, 1'b0);
        @(posedge clock);
        #1;
        instr = '0;
        check_flag(exec_q.branch_take, 1'b1);
    endtask

    initial begin
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        reset_n = 1'b0;
        simd_mode = 1'b0;
        short_word_space = 1'b0;
        exec_mem_busy = 1'b0;
        x_lane_flags = '0;
        y_lane_flags = '0;
        instr = '0;
        repeat (5) @(posedge clock);
        #1;
        reset_n = 1'b1;
        check_flag(|{store_q, exec_q, type10_compute_q, illegal_q, stall_q},
                   1'b0);
        t_store();
        t_load();
        t_branch();
        t_codes();
        t_illegal();
        t_stall();
        complete_run();
    end
endmodule
